// *** match_timer.sv ***
// Eight-bit timer with prescaler, four counting modes, two compare channels and APB access.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "timer_params.svh"
module match_timer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tick_en,
    output logic ch0_out,
    output logic ch1_out,
    output logic irq_req
);
    import timer_pkg::*;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic addr_is(input logic [`ADDR_W-1:0] a, input logic [7:0] idx);
        addr_is = (a == {2'b00, idx, 2'b00});
    endfunction

    logic sel_count;
    logic sel_ctl;
    logic sel_ch0_ctl;
    logic sel_ch0_val;
    logic sel_ch1_ctl;
    logic sel_ch1_val;
    logic sel_pend;
    logic mapped;
    logic wr_access;
    logic wr_en;
    logic setup;
    logic [7:0] wbyte;

    assign sel_count = addr_is(paddr, `IDX_COUNT);
    assign sel_ctl = addr_is(paddr, `IDX_CTL);
    assign sel_ch0_ctl = addr_is(paddr, `IDX_CH0_CTL);
    assign sel_ch0_val = addr_is(paddr, `IDX_CH0_VAL);
    assign sel_ch1_ctl = addr_is(paddr, `IDX_CH1_CTL);
    assign sel_ch1_val = addr_is(paddr, `IDX_CH1_VAL);
    assign sel_pend = addr_is(paddr, `IDX_PENDING);
    assign mapped = sel_count | sel_ctl | sel_ch0_ctl | sel_ch0_val
                    | sel_ch1_ctl | sel_ch1_val | sel_pend;
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite & mapped;
    // Only the low byte lane carries register data.
    assign wr_en = wr_access & pstrb[0];
    assign wbyte = pwdata[7:0];

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [2:0] div_q;
    logic run_q;
    logic wrap_mask_q;
    count_mode_t mode_q;
    logic [7:0] ch0_ctl_q;
    logic [7:0] ch1_ctl_q;
    logic [7:0] ch0_val_q;
    logic [7:0] ch1_val_q;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic up_q;
    logic up_d;
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;

    logic ctl_wr;
    logic clr_req;
    logic load_down;

    assign ctl_wr = wr_en & sel_ctl;
    assign clr_req = ctl_wr & wbyte[`CTL_CLR];
    // Every control write selecting down mode without clear preloads the channel 0 value so the count has a start.
    assign load_down = ctl_wr & ~wbyte[`CTL_CLR]
                       & (count_mode_t'(wbyte[`CTL_MODE_HI:`CTL_MODE_LO]) == MODE_DOWN);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q <= 3'(`CTL_RESET >> `CTL_DIV_LO);
            run_q <= 1'b0;
            wrap_mask_q <= 1'b1;
            mode_q <= MODE_FREE;
        end
        else if (ctl_wr)
        begin
            div_q <= wbyte[`CTL_DIV_HI:`CTL_DIV_LO];
            run_q <= wbyte[`CTL_RUN];
            wrap_mask_q <= wbyte[`CTL_WRAP_MASK];
            mode_q <= count_mode_t'(wbyte[`CTL_MODE_HI:`CTL_MODE_LO]);
        end
    end

    // Bit 7 of the channel control registers is not stored and reads as zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch0_ctl_q <= `CCTL_RESET;
            ch1_ctl_q <= `CCTL_RESET;
        end
        else
        begin
            if (wr_en && sel_ch0_ctl)
                ch0_ctl_q <= {1'b0, wbyte[6:0]};
            if (wr_en && sel_ch1_ctl)
                ch1_ctl_q <= {1'b0, wbyte[6:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch0_val_q <= `CVAL_RESET;
            ch1_val_q <= `CVAL_RESET;
        end
        else
        begin
            if (wr_en && sel_ch0_val)
                ch0_val_q <= wbyte;
            if (wr_en && sel_ch1_val)
                ch1_val_q <= wbyte;
        end
    end

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    logic step;
    logic wrap_evt;

    tick_prescaler u_prescaler
    (
        .pclk(pclk),
        .presetn(presetn),
        .tick_en(tick_en),
        .run(run_q),
        .div(div_q),
        .step(step)
    );

    // Next count for one step. A compare value of zero pins modulo and up/down at zero.
    always_comb
    begin
        count_d = count_q;
        up_d = up_q;
        wrap_evt = 1'b0;
        case (mode_q)
            MODE_FREE:
            begin
                count_d = count_q + 8'h01;
                up_d = 1'b1;
                wrap_evt = (count_q == `COUNT_TOP);
            end
            MODE_DOWN:
            begin
                up_d = 1'b0;
                if (count_q != 8'h00)
                begin
                    count_d = count_q - 8'h01;
                    wrap_evt = (count_q == 8'h01);
                end
            end
            MODE_MODULO:
            begin
                up_d = 1'b1;
                if (count_q >= ch0_val_q)
                begin
                    count_d = 8'h00;
                    wrap_evt = 1'b1;
                end
                else
                    count_d = count_q + 8'h01;
            end
            MODE_UPDOWN:
            begin
                if (up_q && count_q >= ch0_val_q && count_q != 8'h00)
                begin
                    up_d = 1'b0;
                    count_d = count_q - 8'h01;
                    wrap_evt = (count_q == 8'h01);
                end
                else if (up_q)
                    count_d = (ch0_val_q == 8'h00) ? 8'h00 : count_q + 8'h01;
                else if (count_q == 8'h00)
                begin
                    up_d = 1'b1;
                    count_d = (ch0_val_q == 8'h00) ? 8'h00 : 8'h01;
                end
                else
                begin
                    count_d = count_q - 8'h01;
                    wrap_evt = (count_q == 8'h01);
                end
            end
            default:
            begin
                count_d = count_q;
                up_d = up_q;
            end
        endcase
    end

    // Clear beats a load and a step landing in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= `COUNT_RESET;
            up_q <= 1'b1;
        end
        else if (clr_req)
        begin
            count_q <= 8'h00;
            up_q <= 1'b1;
        end
        else if (load_down)
        begin
            count_q <= ch0_val_q;
            up_q <= 1'b0;
        end
        else if (step)
        begin
            count_q <= count_d;
            up_q <= up_d;
        end
    end

    // ------------------------------------------------------------------------
    // Compare channels
    // ------------------------------------------------------------------------
    logic ch0_match;
    logic ch1_match;
    logic count_step;
    logic is_updown;

    // Channels see the step that really lands, so a clear or load suppresses them.
    assign count_step = step & ~clr_req & ~load_down;
    assign is_updown = (mode_q == MODE_UPDOWN);

    match_channel #(.IS_CH1(1'b0)) u_ch0
    (
        .pclk(pclk),
        .presetn(presetn),
        .step(count_step),
        .next_count(count_d),
        .match_val(ch0_val_q),
        .ch0_val(ch0_val_q),
        .count_up(up_d),
        .updown(is_updown),
        .enable(ch0_ctl_q[`CCTL_EN]),
        .action(match_action_t'(ch0_ctl_q[`CCTL_ACT_HI:`CCTL_ACT_LO])),
        .match(ch0_match),
        .pin(ch0_out)
    );

    match_channel #(.IS_CH1(1'b1)) u_ch1
    (
        .pclk(pclk),
        .presetn(presetn),
        .step(count_step),
        .next_count(count_d),
        .match_val(ch1_val_q),
        .ch0_val(ch0_val_q),
        .count_up(up_d),
        .updown(is_updown),
        .enable(ch1_ctl_q[`CCTL_EN]),
        .action(match_action_t'(ch1_ctl_q[`CCTL_ACT_HI:`CCTL_ACT_LO])),
        .match(ch1_match),
        .pin(ch1_out)
    );

    // ------------------------------------------------------------------------
    // Pending flags and interrupt request
    // ------------------------------------------------------------------------
    logic [2:0] pend_set;
    logic [2:0] pend_keep;
    logic [2:0] pend_mask;

    assign pend_set = {ch1_match, ch0_match, count_step & wrap_evt};
    // Writing zero clears a flag; a new event in the same cycle still sets it.
    assign pend_keep = (wr_en && sel_pend) ? wbyte[2:0] : 3'b111;
    assign pend_d = (pend_q & pend_keep) | pend_set;
    assign pend_mask = {ch1_ctl_q[`CCTL_MASK], ch0_ctl_q[`CCTL_MASK], wrap_mask_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pend_q <= 3'b000;
        else
            pend_q <= pend_d;
    end

    assign irq_req = |(pend_q & pend_mask);

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Read data is captured in the setup cycle, so the access phase needs no wait.
    assign rd_mux =
        sel_count ? {24'h000000, count_q} :
        sel_ctl ? {24'h000000, div_q, run_q, wrap_mask_q, 1'b0, mode_q} :
        sel_ch0_ctl ? {24'h000000, ch0_ctl_q} :
        sel_ch0_val ? {24'h000000, ch0_val_q} :
        sel_ch1_ctl ? {24'h000000, ch1_ctl_q} :
        sel_ch1_val ? {24'h000000, ch1_val_q} :
        sel_pend ? {29'h00000000, pend_q} :
        32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (setup)
            prdata_q <= rd_mux;
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
endmodule

// *** timer_params.svh ***
// Register indices, field positions and reset values of the 8-bit timer.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_CH1_CTL 8'hce
`define IDX_CH1_VAL 8'hcf
`define IDX_PENDING 8'hd8
`define IDX_COUNT 8'hea
`define IDX_CTL 8'heb
`define IDX_CH0_CTL 8'hec
`define IDX_CH0_VAL 8'hed
`define ADDR_W 12

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTL_DIV_HI 7
`define CTL_DIV_LO 5
`define CTL_RUN 4
`define CTL_WRAP_MASK 3
`define CTL_CLR 2
`define CTL_MODE_HI 1
`define CTL_MODE_LO 0
`define CTL_RESET 8'h08

// ----------------------------------------------------------------------------
// Channel control register fields
// ----------------------------------------------------------------------------
`define CCTL_MASK 6
`define CCTL_ACT_HI 5
`define CCTL_ACT_LO 3
`define CCTL_EN 2
`define CCTL_RES_HI 1
`define CCTL_RES_LO 0
`define CCTL_RESET 8'h40
`define CVAL_RESET 8'h00
`define COUNT_RESET 8'h00

// ----------------------------------------------------------------------------
// Pending flag positions
// ----------------------------------------------------------------------------
`define PEND_WRAP 0
`define PEND_CH0 1
`define PEND_CH1 2
`define COUNT_TOP 8'hff

`endif

// *** timer_pkg.sv ***
// Types shared by the timer modules.
package timer_pkg;

    typedef enum logic [1:0] {MODE_FREE, MODE_DOWN, MODE_MODULO, MODE_UPDOWN} count_mode_t;

    typedef enum logic [2:0]
    {
        ACT_SET,
        ACT_CLEAR,
        ACT_TOGGLE,
        ACT_SET_UP,
        ACT_CLEAR_UP,
        ACT_SET_ALT,
        ACT_CLEAR_ALT,
        ACT_NONE
    } match_action_t;

endpackage

// *** tick_prescaler.sv ***
// Prescaler that turns the base tick enable into the timer step enable.
`timescale 1ns/1ps
module tick_prescaler
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick_en,
    input wire logic run,
    input wire logic [2:0] div,
    output logic step
);
    import timer_pkg::*;

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] mask_w;

    // A step fires once every two-to-the-div base ticks.
    assign mask_w = 7'((8'h01 << div) - 8'h01);
    assign step = tick_en & run & ((cnt_q & mask_w) == mask_w);
    assign cnt_d = (tick_en & run) ? cnt_q + 7'h01 : cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 7'h00;
        else
            cnt_q <= cnt_d;
    end
endmodule

// *** match_channel.sv ***
// One compare channel: match detection and the output pin action.
`timescale 1ns/1ps
module match_channel
#(
    parameter bit IS_CH1 = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic [7:0] next_count,
    input wire logic [7:0] match_val,
    input wire logic [7:0] ch0_val,
    input wire logic count_up,
    input wire logic updown,
    input wire logic enable,
    input wire timer_pkg::match_action_t action,
    output logic match,
    output logic pin
);
    import timer_pkg::*;

    logic pin_q;
    logic pin_d;
    logic hit_zero;
    logic hit_alt;

    assign match = enable & step & (next_count == match_val);
    assign hit_zero = enable & step & (next_count == 8'h00);
    // Channel 1 uses the channel 0 value as its second event, channel 0 uses zero.
    assign hit_alt = IS_CH1 ? (enable & step & (next_count == ch0_val)) : hit_zero;
    assign pin = pin_q;

    always_comb
    begin
        pin_d = pin_q;
        case (action)
            ACT_SET: if (match) pin_d = 1'b1;
            ACT_CLEAR: if (match) pin_d = 1'b0;
            ACT_TOGGLE: if (match) pin_d = ~pin_q;
            ACT_SET_UP:
            begin
                if (match)
                    pin_d = updown ? count_up : 1'b1;
                else if (hit_zero && !updown)
                    pin_d = 1'b0;
            end
            ACT_CLEAR_UP:
            begin
                if (match)
                    pin_d = updown ? ~count_up : 1'b0;
                else if (hit_zero && !updown)
                    pin_d = 1'b1;
            end
            ACT_SET_ALT:
            begin
                if (match)
                    pin_d = 1'b1;
                else if (hit_alt)
                    pin_d = 1'b0;
            end
            ACT_CLEAR_ALT:
            begin
                if (match)
                    pin_d = 1'b0;
                else if (hit_alt)
                    pin_d = 1'b1;
            end
            default: pin_d = pin_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q <= 1'b0;
        else
            pin_q <= pin_d;
    end
endmodule

// *** match_timer_asserts.sv ***
// Port-level assertions for the eight-bit match timer.
`timescale 1ns/1ps
`include "timer_params.svh"
module match_timer_asserts
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tick_en,
    input wire logic ch0_out,
    input wire logic ch1_out,
    input wire logic irq_req
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    wire [9:0] idx = paddr[11:2];
    wire acc = psel && penable;
    wire rd = acc && !pwrite;
    wire chctl = idx == `IDX_CH0_CTL || idx == `IDX_CH1_CTL;
    wire mapped = paddr[1:0] == 2'b00 && (chctl || idx == `IDX_CH1_VAL
        || idx == `IDX_PENDING || idx == `IDX_COUNT || idx == `IDX_CTL
        || idx == `IDX_CH0_VAL);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_access_ready: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_clear_reads0: assert property (rd && idx == `IDX_CTL |-> !prdata[`CTL_CLR])
        else $error("clear bit read back as one");
    a_chctl_top0: assert property (rd && chctl |-> !prdata[7])
        else $error("channel control bit 7 not zero");
    a_pend_unused: assert property (rd && idx == `IDX_PENDING |-> prdata[7:3] == 5'h0)
        else $error("unused pending bits not zero");
    // The read word is captured in the setup cycle, so the request is compared there too.
    a_irq_needs_flag: assert property (psel && !penable && idx == `IDX_PENDING
        ##1 prdata[2:0] == 3'h0 |-> !$past(irq_req))
        else $error("interrupt with no pending flag");
    a_pins_hold: assert property (!tick_en && !(acc && pwrite)
        |=> $stable(ch0_out) && $stable(ch1_out))
        else $error("pin moved without a step");

    c_irq: cover property ($rose(irq_req));
    c_ch1_pin: cover property ($rose(ch1_out));
    c_refused: cover property (acc && pslverr);
endmodule

bind match_timer match_timer_asserts u_match_timer_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_en(tick_en),
    .ch0_out(ch0_out), .ch1_out(ch1_out), .irq_req(irq_req));

// *** match_timer_tb.sv ***
// Self-checking random testbench for the eight-bit match timer.
`timescale 1ns/1ps
`include "timer_params.svh"
module match_timer_tb;
    logic pclk, presetn, psel, penable, pwrite, tick_en, err;
    logic pready, pslverr, ch0_out, ch1_out, irq_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, seed, v;
    logic [3:0] pstrb;
    logic [7:0] t, vv;
    int fail_count, n_checks, n;
    logic [7:0] idx_tab [7] = '{`IDX_CH1_CTL, `IDX_CH1_VAL, `IDX_PENDING, `IDX_COUNT,
        `IDX_CTL, `IDX_CH0_CTL, `IDX_CH0_VAL};
    logic [7:0] rst_tab [7] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h08, 8'h40, 8'h00};

    match_timer u_match_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_en(tick_en),
        .ch0_out(ch0_out), .ch1_out(ch1_out), .irq_req(irq_req));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Walks the count step by step, as software would expect to see it.
    function logic [7:0] model_count(int mode, logic [7:0] top, int steps);
        logic [7:0] c;
        logic up;
        c = (mode == 1) ? top : 8'h00;
        up = 1'b1;
        for (int i = 0; i < steps; i++)
        begin
            if (mode == 0) c = c + 8'h01;
            else if (mode == 1) c = (c == 8'h00) ? c : c - 8'h01;
            else if (mode == 2) c = (c == top) ? 8'h00 : c + 8'h01;
            else
            begin
                if (up && c == top) up = 1'b0;
                else if (!up && c == 8'h00) up = 1'b1;
                c = up ? c + 8'h01 : c - 8'h01;
            end
        end
        return c;
    endfunction

    task finish_test();
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(logic wr, logic [7:0] idx, logic [7:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            finish_test();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(logic [7:0] idx, logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rdat, {24'h0, exp});
    endtask

    task ticks(int cnt);
        repeat (cnt)
        begin
            @(posedge pclk);
            tick_en <= 1'b1;
            @(posedge pclk);
            tick_en <= 1'b0;
        end
        // Pins launched by the last step settle before the caller looks at them.
        @(negedge pclk);
    endtask

    task rst();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 32'd95;
        fail_count = 0;
        n_checks = 0;
        {presetn, psel, penable, pwrite, tick_en, paddr, pwdata} = '0;
        pstrb = 4'hf;
        rst();
        foreach (idx_tab[i]) rd(idx_tab[i], rst_tab[i]);
        apb(1'b0, 8'h00, 8'h00);
        chk({31'h0, err}, 32'h1);
        pstrb <= 4'he;
        apb(1'b1, `IDX_CH0_VAL, 8'h5a);
        pstrb <= 4'hf;
        rd(`IDX_CH0_VAL, 8'h00);
        repeat (4)
        begin
            v = rnd();
            apb(1'b1, `IDX_CH1_VAL, v[7:0]);
            apb(1'b1, `IDX_CH0_VAL, v[15:8]);
            apb(1'b1, `IDX_CH1_CTL, v[23:16] & 8'hfc);
            apb(1'b1, `IDX_COUNT, v[31:24]);
            rd(`IDX_CH1_VAL, v[7:0]);
            rd(`IDX_CH0_VAL, v[15:8]);
            rd(`IDX_CH1_CTL, v[23:16] & 8'h7c);
            rd(`IDX_COUNT, 8'h00);
        end
        for (int d = 0; d < 8; d++)
        begin
            rst();
            apb(1'b1, `IDX_CTL, {d[2:0], 5'b11000});
            ticks((3 << d) - 1);
            rd(`IDX_COUNT, 8'h02);
            ticks(1);
            rd(`IDX_COUNT, 8'h03);
            apb(1'b1, `IDX_CTL, {d[2:0], 5'b01000});
            ticks(4 << d);
            rd(`IDX_COUNT, 8'h03);
            apb(1'b1, `IDX_CTL, {d[2:0], 5'b11100});
            rd(`IDX_COUNT, 8'h00);
            rd(`IDX_CTL, {d[2:0], 5'b11000});
        end
        for (int m = 0; m < 8; m++)
        begin
            rst();
            t = rnd() % 254 + 2;
            n = rnd() % 600 + 1;
            apb(1'b1, `IDX_CH0_VAL, t);
            apb(1'b1, `IDX_CTL, (m % 4 == 1) ? 8'h19 : 8'h1c | m[1:0]);
            ticks(n);
            rd(`IDX_COUNT, model_count(m % 4, t, n));
        end
        rst();
        apb(1'b1, `IDX_CTL, 8'h18);
        ticks(255);
        rd(`IDX_COUNT, 8'hff);
        ticks(1);
        rd(`IDX_COUNT, 8'h00);
        rd(`IDX_PENDING, 8'h01);
        chk(irq_req, 32'h1);
        apb(1'b1, `IDX_PENDING, 8'hff);
        rd(`IDX_PENDING, 8'h01);
        apb(1'b1, `IDX_CTL, 8'h10);
        @(negedge pclk);
        chk(irq_req, 32'h0);
        apb(1'b1, `IDX_PENDING, 8'h00);
        rd(`IDX_PENDING, 8'h00);
        // Tables below hold the expected pin, one bit per action code.
        for (int a = 0; a < 8; a++)
        begin
            rst();
            t = rnd() % 200 + 20;
            vv = rnd() % (t - 2) + 1;
            apb(1'b1, `IDX_CH0_VAL, t);
            apb(1'b1, `IDX_CH1_VAL, vv);
            apb(1'b1, `IDX_CH0_CTL, 8'h44 | (a[2:0] << 3));
            apb(1'b1, `IDX_CH1_CTL, 8'h44 | (a[2:0] << 3));
            apb(1'b1, `IDX_CTL, 8'h1e);
            ticks(vv);
            chk(ch1_out, 8'h2d >> a & 1);
            chk(ch0_out, 32'h0);
            ticks(t - vv);
            chk(ch1_out, 8'h4d >> a & 1);
            chk(ch0_out, 8'h2d >> a & 1);
            ticks(1);
            chk(ch1_out, 8'h55 >> a & 1);
            chk(ch0_out, 8'h55 >> a & 1);
            rd(`IDX_PENDING, 8'h07);
            chk(irq_req, 32'h1);
        end
        rst();
        apb(1'b1, `IDX_CH0_VAL, 8'h05);
        apb(1'b1, `IDX_CH0_CTL, 8'h40);
        apb(1'b1, `IDX_CTL, 8'h1e);
        ticks(6);
        chk(ch0_out, 32'h0);
        rd(`IDX_PENDING, 8'h01);
        for (int a = 3; a < 5; a++)
        begin
            rst();
            t = rnd() % 100 + 50;
            vv = t / 2;
            apb(1'b1, `IDX_CH0_VAL, t);
            apb(1'b1, `IDX_CH1_VAL, vv);
            apb(1'b1, `IDX_CH1_CTL, 8'h44 | (a[2:0] << 3));
            apb(1'b1, `IDX_CTL, 8'h1f);
            ticks(vv);
            chk(ch1_out, a == 3);
            ticks(2 * (t - vv));
            chk(ch1_out, a == 4);
        end
        finish_test();
    end
endmodule
